// ### core/ltssm_pkg.sv
// Constants and types for the receiver-detect quiet and polling link trainer
package ltssm_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;

  // Times in their own units
  localparam int unsigned T_QUIET_MS = 12;
  localparam int unsigned T_LFPS_MS = 360;
  localparam int unsigned T_TRAIN_MS = 12;
  localparam int unsigned T_IDLE_MS = 2;
  localparam int unsigned T_LFPS_OP_US = 80;
  localparam int unsigned T_EQ_SKIP_US = 30;

  // Cycle counts; whole numbers at 50 MHz, so no rounding applies
  localparam int unsigned QUIET_CYC = T_QUIET_MS * CYC_PER_MS;
  localparam int unsigned LFPS_CYC = T_LFPS_MS * CYC_PER_MS;
  localparam int unsigned TRAIN_CYC = T_TRAIN_MS * CYC_PER_MS;
  localparam int unsigned IDLE_CYC = T_IDLE_MS * CYC_PER_MS;
  localparam int unsigned LFPS_OP_CYC = T_LFPS_OP_US * CYC_PER_US;
  localparam int unsigned EQ_SKIP_CYC = T_EQ_SKIP_US * CYC_PER_US;

  localparam int TIMER_W = 25;
  localparam int SETTLE_W = 13;

  // Handshake counts
  localparam logic [16:0] LFPS_TX_MIN = 17'h00010;
  localparam logic [16:0] TSEQ_TX_CNT = 17'h10000;
  localparam logic [3:0] LFPS_RX_MIN = 4'h2;
  localparam logic [4:0] LFPS_AFT_MIN = 5'h04;
  localparam logic [3:0] TS_RX_MIN = 4'h8;
  localparam logic [4:0] TS2_AFT_MIN = 5'h10;
  localparam logic [3:0] IDLE_RX_MIN = 4'h8;
  localparam logic [4:0] IDLE_AFT_MIN = 5'h10;

  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam int CTRL_ROLE_LSB = 0;
  localparam int CTRL_DISABLE_BIT = 2;
  localparam int CTRL_WARM_BIT = 3;
  localparam int CTRL_HOT_BIT = 4;
  localparam int CTRL_LOOP_BIT = 5;
  localparam int CTRL_SCR_OFF_BIT = 6;
  localparam int CTRL_LB_CAP_BIT = 7;
  localparam int CTRL_RESTART_BIT = 8;
  localparam int STAT_TRAINED_BIT = 16;
  localparam int STAT_SCR_BIT = 17;
  localparam int STAT_LB_SLAVE_BIT = 18;

  localparam logic [1:0] ROLE_DOWN = 2'h0;
  localparam logic [1:0] ROLE_HUB_UP = 2'h1;
  localparam logic [1:0] ROLE_PERIPH = 2'h2;

  typedef enum logic [11:0] {
    ST_DETECT = 12'h001,
    ST_QUIET = 12'h002,
    ST_LFPS = 12'h004,
    ST_RXEQ = 12'h008,
    ST_ACTIVE = 12'h010,
    ST_CONFIG = 12'h020,
    ST_IDLE = 12'h040,
    ST_U0 = 12'h080,
    ST_LOOPBACK = 12'h100,
    ST_HOT_RESET = 12'h200,
    ST_COMPLIANCE = 12'h400,
    ST_DISABLED = 12'h800
  } lt_state_t;

  typedef struct packed {
    logic reset;
    logic loopback;
    logic scr_off;
  } link_cfg_t;

  typedef struct packed {
    logic is_ts2;
    link_cfg_t cfg;
  } ts_rx_t;

  typedef struct packed {
    logic lb_cap;
    logic scr_off;
    logic loopback;
    logic hot_reset;
    logic warm_reset;
    logic disable_req;
    logic [1:0] role;
  } ctrl_t;

  // One-cycle event pulses, plus the phy_ready level, from the lane logic, same clock
  typedef struct packed {
    logic lfps_sent;
    logic lfps_rcvd;
    logic lfps_break;
    logic phy_ready;
    logic tseq_sent;
    logic ts_valid;
    logic ts_sent;
    logic idle_rcvd;
    logic idle_break;
    logic idle_sent;
    logic term_found;
    logic term_absent;
    logic warm_det;
  } phy_ev_t;

  typedef struct packed {
    logic det_en;
    logic lfps_rx_en;
    logic lfps_op;
    logic lfps_tx_en;
    logic polarity_en;
    logic eq_train;
    logic tseq_tx;
    logic ts1_tx;
    logic ts2_tx;
    link_cfg_t ts2_cfg;
    logic idle_tx;
    logic hsn_rx_en;
    logic scramble_en;
    logic lb_slave;
    logic link_err_clr;
    logic port_cfg_dflt;
  } phy_ctl_t;

endpackage

// ### core/link_trainer.sv
// Link trainer: detect quiet substate and polling substates with register slave
//
// Function
// - Quiet detect: termination detect off, 12 ms timer, then back to active detect.
// - Downstream port goes disabled when directed in quiet and polling substates.
// - Directed warm reset (downstream) or detected warm reset (upstream) returns to detect.
// - Polling LFPS: receiver on, operating within 80 us, 360 ms timer, PHY ready.
// - Exit LFPS after 16 sent, 2 consecutive received, 4 sent after first received.
// - LFPS timeout without ever completing handshake since power-on enters compliance.
// - LFPS timeout after earlier training: detect, or disabled for a peripheral.
// - Equalization substate: polarity correction on, TSEQ sent, equalizer trained while in it.
// - Equalizer ignores the first 30 us of received TSEQ.
// - Leave equalization after 65536 consecutive TSEQ sets sent.
// - Active substate: 12 ms timer, TS1 sent, receiver trains.
// - Advance to configuration after eight consecutive identical TS1 or TS2.
// - Active or configuration timeout: detect, or disabled for a peripheral.
// - Configuration: 12 ms timer, TS2 with reset (downstream only), loopback, scramble-off bits when directed.
// - Exit configuration after eight identical TS2 received, sixteen sent after first.
// - Idle decodes TS2; downstream clears error count, upstream restores defaults.
// - Scrambling on by default, off if directed or TS2 asked for it.
// - Idle: 2 ms timer, idle symbols toward U0, sequence adverts accepted, timeout fallback.
// - Loopback master when directed and capable; slave when TS2 loopback bit set.
// - Hot reset when directed (downstream) or TS2 reset bit set (upstream).
// - Enter U0 after eight idle symbols received, sixteen sent after first received.
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module link_trainer #(
  parameter logic [24:0] QUIET_CYC = 25'(ltssm_pkg::QUIET_CYC),
  parameter logic [24:0] LFPS_CYC = 25'(ltssm_pkg::LFPS_CYC),
  parameter logic [24:0] TRAIN_CYC = 25'(ltssm_pkg::TRAIN_CYC),
  parameter logic [24:0] IDLE_CYC = 25'(ltssm_pkg::IDLE_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ltssm_pkg::phy_ev_t ev_i,
  input wire ltssm_pkg::ts_rx_t ts_rx_i,
  output ltssm_pkg::phy_ctl_t ctl_o,
  output ltssm_pkg::lt_state_t state_o
);

  typedef struct packed {
    ltssm_pkg::lt_state_t st;
    logic [ltssm_pkg::TIMER_W-1:0] timer;
    logic [ltssm_pkg::SETTLE_W-1:0] settle;
    logic [16:0] txcnt;
    logic [3:0] rxcnt;
    logic [4:0] aftcnt;
    logic seen_first;
    ltssm_pkg::ts_rx_t last_ts;
    ltssm_pkg::link_cfg_t rx_cfg;
    logic trained_once;
    ltssm_pkg::ctrl_t ctrl;
    logic restart;
    logic ack;
    logic [31:0] rdata;
    ltssm_pkg::phy_ctl_t o;
  } core_t;

  core_t s;
  core_t next_s;

  logic [31:0] ctrl_word;
  logic [31:0] wr_word;
  logic [24:0] lim;
  logic expire;
  logic down;
  logic periph;
  logic warm;
  logic dis;
  logic bus_req;
  logic lfps_ok;
  ltssm_pkg::lt_state_t fail_st;

  always_comb begin
    down = s.ctrl.role == ltssm_pkg::ROLE_DOWN;
    periph = s.ctrl.role == ltssm_pkg::ROLE_PERIPH;
    warm = down ? s.ctrl.warm_reset : ev_i.warm_det;
    dis = down & s.ctrl.disable_req;
    fail_st = periph ? ltssm_pkg::ST_DISABLED : ltssm_pkg::ST_DETECT;
    case (s.st)
      ltssm_pkg::ST_QUIET: lim = QUIET_CYC;
      ltssm_pkg::ST_LFPS: lim = LFPS_CYC;
      ltssm_pkg::ST_ACTIVE: lim = TRAIN_CYC;
      ltssm_pkg::ST_CONFIG: lim = TRAIN_CYC;
      ltssm_pkg::ST_IDLE: lim = IDLE_CYC;
      default: lim = QUIET_CYC;
    endcase
    expire = s.timer == lim - 25'h0000001;
    ctrl_word = {23'h000000, s.restart, s.ctrl};
    wr_word = ctrl_word;
    for (int b = 0; b < 4; b++) begin
      if (wb_sel_i[b]) begin
        wr_word[b*8 +: 8] = wb_dat_i[b*8 +: 8];
      end
    end
    bus_req = wb_cyc_i & wb_stb_i & ~s.ack;
    // handshake exit, gated by PHY ready and settle time
    lfps_ok = (s.txcnt >= ltssm_pkg::LFPS_TX_MIN) & (s.rxcnt >= ltssm_pkg::LFPS_RX_MIN)
      & (s.aftcnt >= ltssm_pkg::LFPS_AFT_MIN) & ev_i.phy_ready & s.o.lfps_op;
  end

  always_comb begin
    next_s = s;
    next_s.restart = 1'b0;
    next_s.ack = bus_req;
    next_s.timer = expire ? s.timer : s.timer + 25'h0000001;
    if (s.settle != {ltssm_pkg::SETTLE_W{1'b1}}) begin
      next_s.settle = s.settle + 13'h0001;
    end

    // Register slave; unmapped reads answer zero
    if (bus_req) begin
      next_s.rdata = 32'h00000000;
      if (wb_adr_i == ltssm_pkg::CTRL_OFS) begin
        next_s.rdata = ctrl_word;
        if (wb_we_i) begin
          next_s.ctrl = wr_word[7:0];
          next_s.restart = wr_word[ltssm_pkg::CTRL_RESTART_BIT];
        end
      end else if (wb_adr_i == ltssm_pkg::STAT_OFS) begin
        next_s.rdata[11:0] = s.st;
        next_s.rdata[ltssm_pkg::STAT_TRAINED_BIT] = s.trained_once;
        next_s.rdata[ltssm_pkg::STAT_SCR_BIT] = s.o.scramble_en;
        next_s.rdata[ltssm_pkg::STAT_LB_SLAVE_BIT] = s.o.lb_slave;
      end
    end

    case (s.st)
      ltssm_pkg::ST_DETECT: begin
        if (dis) begin
          next_s.st = ltssm_pkg::ST_DISABLED;
        end else if (ev_i.term_found) begin
          next_s.st = ltssm_pkg::ST_LFPS;
        end else if (ev_i.term_absent) begin
          next_s.st = ltssm_pkg::ST_QUIET;
        end
      end
      ltssm_pkg::ST_QUIET: begin
        if (dis) begin
          next_s.st = ltssm_pkg::ST_DISABLED;
        end else if (warm) begin
          next_s.st = ltssm_pkg::ST_DETECT;
        end else if (expire) begin
          // quiet timer back to active detect
          next_s.st = ltssm_pkg::ST_DETECT;
        end
      end
      ltssm_pkg::ST_LFPS: begin
        if (ev_i.lfps_sent && s.txcnt < ltssm_pkg::LFPS_TX_MIN) begin
          next_s.txcnt = s.txcnt + 17'h00001;
        end
        if (ev_i.lfps_break) begin
          next_s.rxcnt = 4'h0;
        end else if (ev_i.lfps_rcvd && s.rxcnt < ltssm_pkg::LFPS_RX_MIN) begin
          next_s.rxcnt = s.rxcnt + 4'h1;
        end
        if (ev_i.lfps_rcvd) begin
          next_s.seen_first = 1'b1;
        end
        if (ev_i.lfps_sent && s.seen_first && s.aftcnt < ltssm_pkg::LFPS_AFT_MIN) begin
          next_s.aftcnt = s.aftcnt + 5'h01;
        end
        if (dis) begin
          next_s.st = ltssm_pkg::ST_DISABLED;
        end else if (warm) begin
          next_s.st = ltssm_pkg::ST_DETECT;
        end else if (lfps_ok) begin
          next_s.trained_once = 1'b1;
          next_s.st = ltssm_pkg::ST_RXEQ;
        end else if (expire) begin
          // first failure means a test load
          next_s.st = s.trained_once ? fail_st : ltssm_pkg::ST_COMPLIANCE;
        end
      end
      ltssm_pkg::ST_RXEQ: begin
        if (ev_i.tseq_sent) begin
          next_s.txcnt = s.txcnt + 17'h00001;
        end
        if (dis) begin
          next_s.st = ltssm_pkg::ST_DISABLED;
        end else if (warm) begin
          next_s.st = ltssm_pkg::ST_DETECT;
        end else if (s.txcnt == ltssm_pkg::TSEQ_TX_CNT) begin
          next_s.st = ltssm_pkg::ST_ACTIVE;
        end
      end
      ltssm_pkg::ST_ACTIVE, ltssm_pkg::ST_CONFIG: begin
        if (ts_rx_i.is_ts2 || s.st == ltssm_pkg::ST_ACTIVE) begin
          if (ev_i.ts_valid) begin
            next_s.last_ts = ts_rx_i;
            if (s.rxcnt != 4'h0 && ts_rx_i == s.last_ts) begin
              if (s.rxcnt < ltssm_pkg::TS_RX_MIN) begin
                next_s.rxcnt = s.rxcnt + 4'h1;
              end
            end else begin
              next_s.rxcnt = 4'h1;
              next_s.aftcnt = 5'h00;
              next_s.seen_first = 1'b1;
            end
          end
        end else if (ev_i.ts_valid) begin
          next_s.rxcnt = 4'h0;
          next_s.seen_first = 1'b0;
        end
        // TS2 sent after first of the run
        if (ev_i.ts_sent && s.seen_first && !(ev_i.ts_valid && next_s.rxcnt == 4'h1)
            && s.aftcnt < ltssm_pkg::TS2_AFT_MIN) begin
          next_s.aftcnt = s.aftcnt + 5'h01;
        end
        if (dis) begin
          next_s.st = ltssm_pkg::ST_DISABLED;
        end else if (warm) begin
          next_s.st = ltssm_pkg::ST_DETECT;
        end else if (s.st == ltssm_pkg::ST_ACTIVE && s.rxcnt == ltssm_pkg::TS_RX_MIN) begin
          next_s.st = ltssm_pkg::ST_CONFIG;
        end else if (s.st == ltssm_pkg::ST_CONFIG && s.rxcnt == ltssm_pkg::TS_RX_MIN
            && s.aftcnt >= ltssm_pkg::TS2_AFT_MIN) begin
          next_s.rx_cfg = s.last_ts.cfg;
          next_s.st = ltssm_pkg::ST_IDLE;
        end else if (expire) begin
          next_s.st = fail_st;
        end
      end
      ltssm_pkg::ST_IDLE: begin
        if (ev_i.idle_break) begin
          next_s.rxcnt = 4'h0;
        end else if (ev_i.idle_rcvd && s.rxcnt < ltssm_pkg::IDLE_RX_MIN) begin
          next_s.rxcnt = s.rxcnt + 4'h1;
        end
        if (ev_i.idle_rcvd) begin
          next_s.seen_first = 1'b1;
        end
        if (ev_i.idle_sent && s.seen_first && s.aftcnt < ltssm_pkg::IDLE_AFT_MIN) begin
          next_s.aftcnt = s.aftcnt + 5'h01;
        end
        if (dis) begin
          next_s.st = ltssm_pkg::ST_DISABLED;
        end else if (warm) begin
          next_s.st = ltssm_pkg::ST_DETECT;
        end else if ((s.ctrl.loopback && s.ctrl.lb_cap) || s.rx_cfg.loopback) begin
          next_s.st = ltssm_pkg::ST_LOOPBACK;
        end else if (down ? s.ctrl.hot_reset : s.rx_cfg.reset) begin
          next_s.st = ltssm_pkg::ST_HOT_RESET;
        end else if (s.rxcnt == ltssm_pkg::IDLE_RX_MIN && s.aftcnt >= ltssm_pkg::IDLE_AFT_MIN) begin
          next_s.st = ltssm_pkg::ST_U0;
        end else if (expire) begin
          next_s.st = fail_st;
        end
      end
      ltssm_pkg::ST_DISABLED: begin
        if (s.restart) begin
          next_s.st = ltssm_pkg::ST_DETECT;
        end
      end
      default: begin
        // Later states belong to other logic; warm reset or software restart retrains
        if (warm || s.restart) begin
          next_s.st = ltssm_pkg::ST_DETECT;
        end
      end
    endcase

    // Fresh timers and counters on every substate entry
    if (next_s.st != s.st) begin
      next_s.timer = '0;
      next_s.settle = '0;
      next_s.txcnt = '0;
      next_s.rxcnt = '0;
      next_s.aftcnt = '0;
      next_s.seen_first = 1'b0;
    end

    // Registered outputs follow the next state
    next_s.o.det_en = next_s.st == ltssm_pkg::ST_DETECT;
    next_s.o.lfps_rx_en = next_s.st == ltssm_pkg::ST_LFPS;
    next_s.o.lfps_op = next_s.o.lfps_rx_en && next_s.settle >= 13'(ltssm_pkg::LFPS_OP_CYC);
    next_s.o.lfps_tx_en = next_s.o.lfps_op;
    next_s.o.polarity_en = next_s.st == ltssm_pkg::ST_RXEQ;
    next_s.o.tseq_tx = next_s.st == ltssm_pkg::ST_RXEQ;
    next_s.o.eq_train = next_s.o.tseq_tx && next_s.settle >= 13'(ltssm_pkg::EQ_SKIP_CYC);
    next_s.o.ts1_tx = next_s.st == ltssm_pkg::ST_ACTIVE;
    next_s.o.ts2_tx = next_s.st == ltssm_pkg::ST_CONFIG;
    next_s.o.ts2_cfg.reset = down & next_s.ctrl.hot_reset;
    next_s.o.ts2_cfg.loopback = next_s.ctrl.loopback;
    next_s.o.ts2_cfg.scr_off = next_s.ctrl.scr_off;
    // idle symbols only when heading to U0
    next_s.o.idle_tx = next_s.st == ltssm_pkg::ST_IDLE && !next_s.rx_cfg.loopback
      && !(next_s.ctrl.loopback && next_s.ctrl.lb_cap)
      && !(down ? next_s.ctrl.hot_reset : next_s.rx_cfg.reset);
    next_s.o.hsn_rx_en = next_s.st == ltssm_pkg::ST_IDLE;
    next_s.o.link_err_clr = next_s.st == ltssm_pkg::ST_IDLE && s.st != ltssm_pkg::ST_IDLE && down;
    next_s.o.port_cfg_dflt = next_s.st == ltssm_pkg::ST_IDLE && s.st != ltssm_pkg::ST_IDLE && !down;
    if (next_s.st == ltssm_pkg::ST_IDLE && s.st != ltssm_pkg::ST_IDLE) begin
      next_s.o.scramble_en = !(s.ctrl.scr_off || s.last_ts.cfg.scr_off);
    end
    if (next_s.st == ltssm_pkg::ST_LOOPBACK && s.st == ltssm_pkg::ST_IDLE) begin
      next_s.o.lb_slave = !(s.ctrl.loopback && s.ctrl.lb_cap);
    end
    if (next_s.st == ltssm_pkg::ST_DETECT) begin
      next_s.o.lb_slave = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= ltssm_pkg::ST_DETECT;
      s.ctrl <= ltssm_pkg::CTRL_RST[7:0];
      s.o.det_en <= 1'b1;
      s.o.scramble_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign ctl_o = s.o;
  assign state_o = s.st;

endmodule // link_trainer

// ### testbench/link_partner.sv
// Behavioural lane logic and far-end port that feed the trainer's link events
`timescale 1ns/1ps
module link_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic talk_i,
  input wire ltssm_pkg::phy_ctl_t ctl_i,
  output ltssm_pkg::phy_ev_t ev_o,
  output ltssm_pkg::ts_rx_t ts_rx_o
);
  logic [1:0] tick;
  logic beat;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick <= 2'h0;
    end else begin
      tick <= tick + 2'h1;
    end
  end
  // Slow far end: one burst or set every fourth cycle, except TSEQ sets, sent every cycle
  assign beat = (tick == 2'h3);
  always_comb begin
    ev_o = '0;
    ev_o.phy_ready = 1'b1;
    ev_o.lfps_sent = beat & ctl_i.lfps_tx_en;
    ev_o.lfps_rcvd = beat & talk_i & ctl_i.lfps_rx_en;
    ev_o.tseq_sent = ctl_i.tseq_tx;
    ev_o.ts_valid = beat & talk_i & (ctl_i.ts1_tx | ctl_i.ts2_tx);
    ev_o.ts_sent = beat & ctl_i.ts2_tx;
    ev_o.idle_rcvd = beat & talk_i & ctl_i.idle_tx;
    ev_o.idle_sent = beat & ctl_i.idle_tx;
  end
  // Between sets the data wanders, but at tick 2 it equals the valid value 4'h9, so only ts_valid marks a set
  assign ts_rx_o = ev_o.ts_valid ? ltssm_pkg::ts_rx_t'(4'h9) : ltssm_pkg::ts_rx_t'({tick, ~tick});
endmodule // link_partner

// ### testbench/link_trainer_properties.sv
// Port-level assertions for the link trainer
`timescale 1ns/1ps
module link_trainer_properties #(
  parameter logic [24:0] QUIET_CYC = 25'(ltssm_pkg::QUIET_CYC),
  parameter logic [24:0] LFPS_CYC = 25'(ltssm_pkg::LFPS_CYC),
  parameter logic [24:0] TRAIN_CYC = 25'(ltssm_pkg::TRAIN_CYC),
  parameter logic [24:0] IDLE_CYC = 25'(ltssm_pkg::IDLE_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ltssm_pkg::phy_ev_t ev_i,
  input wire ltssm_pkg::ts_rx_t ts_rx_i,
  input wire ltssm_pkg::phy_ctl_t ctl_o,
  input wire ltssm_pkg::lt_state_t state_o
);
  ltssm_pkg::lt_state_t last;
  logic [24:0] age;
  logic [16:0] tseq_n;
  logic same;
  // Age is stale in the entry cycle, hence the same-state guard
  always_ff @(posedge clk_i) begin
    last <= state_o;
    age <= (rst_i || state_o != last) ? 25'h0 : age + 25'h1;
    tseq_n <= (state_o != ltssm_pkg::ST_RXEQ) ? 17'h0 : tseq_n + 17'(ev_i.tseq_sent);
  end
  assign same = (state_o == last);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bus_ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge not a single pulse");
  quiet_det_off_a: assert property (state_o == ltssm_pkg::ST_QUIET |-> !ctl_o.det_en)
    else $error("detection enabled in quiet");
  quiet_timer_a: assert property (same && state_o == ltssm_pkg::ST_QUIET |-> age <= QUIET_CYC)
    else $error("quiet overstayed its timer");
  quiet_exit_a: assert property ($past(state_o) == ltssm_pkg::ST_QUIET && state_o != ltssm_pkg::ST_QUIET
    |-> state_o inside {ltssm_pkg::ST_DETECT, ltssm_pkg::ST_DISABLED}) else $error("bad quiet exit");
  lfps_rx_on_a: assert property (state_o == ltssm_pkg::ST_LFPS |-> ctl_o.lfps_rx_en)
    else $error("burst receiver off in handshake");
  lfps_op_time_a: assert property (same && state_o == ltssm_pkg::ST_LFPS
    && age >= 25'(ltssm_pkg::LFPS_OP_CYC) |-> ctl_o.lfps_op) else $error("operating condition late");
  lfps_timer_a: assert property (same && state_o == ltssm_pkg::ST_LFPS |-> age <= LFPS_CYC)
    else $error("handshake overstayed its timer");
  rxeq_drive_a: assert property (state_o == ltssm_pkg::ST_RXEQ |-> ctl_o.polarity_en && ctl_o.tseq_tx)
    else $error("equalization outputs wrong");
  rxeq_count_a: assert property (state_o == ltssm_pkg::ST_ACTIVE && last == ltssm_pkg::ST_RXEQ
    |-> tseq_n >= 17'h10000) else $error("equalization left early");
  active_ts1_a: assert property (state_o == ltssm_pkg::ST_ACTIVE |-> ctl_o.ts1_tx && !ctl_o.ts2_tx)
    else $error("active not sending TS1");
  config_ts2_a: assert property (state_o == ltssm_pkg::ST_CONFIG |-> ctl_o.ts2_tx && !ctl_o.ts1_tx)
    else $error("configuration not sending TS2");
  train_timer_a: assert property (same && state_o inside {ltssm_pkg::ST_ACTIVE, ltssm_pkg::ST_CONFIG}
    |-> age <= TRAIN_CYC) else $error("training overstayed its timer");
  idle_timer_a: assert property (same && state_o == ltssm_pkg::ST_IDLE |-> age <= IDLE_CYC && ctl_o.hsn_rx_en)
    else $error("idle timer or advert receive wrong");
  u0_entry_a: assert property (state_o == ltssm_pkg::ST_U0 && last == ltssm_pkg::ST_IDLE |-> $past(ctl_o.idle_tx))
    else $error("operational entry without idle symbols");
  cover property (state_o == ltssm_pkg::ST_U0);
  cover property (state_o == ltssm_pkg::ST_COMPLIANCE);
  cover property (same && state_o == ltssm_pkg::ST_QUIET);
endmodule // link_trainer_properties
bind link_trainer link_trainer_properties #(.QUIET_CYC(QUIET_CYC), .LFPS_CYC(LFPS_CYC), .TRAIN_CYC(TRAIN_CYC),
  .IDLE_CYC(IDLE_CYC)) props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ev_i(ev_i), .ts_rx_i(ts_rx_i), .ctl_o(ctl_o), .state_o(state_o));

// ### testbench/superspeed_link_training_polling_bench.sv
// Self-checking bench for the link trainer
`timescale 1ns/1ps
module superspeed_link_training_polling_bench;
  typedef struct packed {logic we; logic [7:0] adr; logic [31:0] dat; logic [31:0] exp;} row_t;
  // Short timers keep the run small
  localparam logic [24:0] L_LIM = 25'h001388;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, talk;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  ltssm_pkg::phy_ev_t p_ev, b_ev, ev;
  ltssm_pkg::ts_rx_t ts_rx;
  ltssm_pkg::phy_ctl_t ctl;
  ltssm_pkg::lt_state_t state;
  int failures, samples_checked, cycles;
  row_t rows [7];
  assign ev = ltssm_pkg::phy_ev_t'(p_ev | b_ev);
  link_trainer #(.QUIET_CYC(25'h0000c8), .LFPS_CYC(L_LIM), .TRAIN_CYC(25'h0000c8), .IDLE_CYC(25'h000064)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .ev_i(ev), .ts_rx_i(ts_rx),
    .ctl_o(ctl), .state_o(state));
  link_partner far_end (.clk_i(clk_i), .rst_i(rst_i), .talk_i(talk), .ctl_i(ctl), .ev_o(p_ev), .ts_rx_o(ts_rx));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we} <= {2'h3, we};
    wb_adr <= a;
    wb_wdat <= d;
    // Ack is registered, so it is settled at the edge that samples it
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    {wb_cyc, wb_stb, wb_we} <= 3'h0;
    @(posedge clk_i);
  endtask
  task automatic wait_st(input ltssm_pkg::lt_state_t s, input int lim);
    int n;
    n = 0;
    while (state !== s && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk("state", 32'(s), 32'(state));
  endtask
  task automatic pulse_term(input logic found);
    @(posedge clk_i);
    b_ev.term_found <= found;
    b_ev.term_absent <= !found;
    @(posedge clk_i);
    b_ev <= '0;
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Ceiling covers one full equalization plus three handshake timeouts
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 95000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    {wb_cyc, wb_stb, wb_we, talk, rst_i} = 5'h01;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_wdat = 32'h0;
    b_ev = '0;
    rows = '{'{1'b1, 8'h00, 32'h000000c1, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'h000000c1},
      '{1'b1, 8'h08, 32'h000000ff, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h0}, '{1'b1, 8'h04, 32'hffffffff, 32'h0},
      '{1'b0, 8'h04, 32'h0, 32'h00020001}, '{1'b1, 8'h00, 32'h0, 32'h0}};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("reset state", 32'h001, 32'(state));
    chk("reset det scramble", 32'h3, {30'h0, ctl.det_en, ctl.scramble_en});
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) chk("register read", rows[i].exp, q);
    end
    pulse_term(1'b1);
    wait_st(ltssm_pkg::ST_LFPS, 10); // handshake entry
    wait_st(ltssm_pkg::ST_COMPLIANCE, 5100); // first failure
    wb(1'b1, 8'h00, 32'h00000100);
    wait_st(ltssm_pkg::ST_DETECT, 10);
    pulse_term(1'b0);
    wait_st(ltssm_pkg::ST_QUIET, 10); // quiet entry
    chk("det_en", 32'h0, 32'(ctl.det_en)); // detection off
    wait_st(ltssm_pkg::ST_DETECT, 210); // quiet timeout
    @(posedge clk_i);
    talk <= 1'b1;
    pulse_term(1'b1);
    wait_st(ltssm_pkg::ST_RXEQ, 5000); // handshake done
    chk("eq_train early", 32'h0, 32'(ctl.eq_train));
    repeat (1600) @(negedge clk_i);
    chk("eq_train late", 32'h1, 32'(ctl.eq_train));
    wait_st(ltssm_pkg::ST_ACTIVE, 65600); // equalization count
    wait_st(ltssm_pkg::ST_CONFIG, 200); // eight sets
    wait_st(ltssm_pkg::ST_IDLE, 200); // TS2 exchange
    chk("idle entry", 32'h5, {29'h0, ctl.link_err_clr, ctl.port_cfg_dflt, ctl.idle_tx});
    wait_st(ltssm_pkg::ST_U0, 100); // idle exchange
    chk("scramble_en", 32'h0, 32'(ctl.scramble_en)); // far end asked
    wb(1'b0, 8'h04, 32'h0);
    chk("trained flag", 32'h1, 32'(q[16])); // flag set
    @(posedge clk_i);
    talk <= 1'b0;
    wb(1'b1, 8'h00, 32'h00000100);
    wait_st(ltssm_pkg::ST_DETECT, 10);
    pulse_term(1'b1);
    wait_st(ltssm_pkg::ST_LFPS, 10);
    wait_st(ltssm_pkg::ST_DETECT, 5100); // retrain timeout
    pulse_term(1'b1);
    wait_st(ltssm_pkg::ST_LFPS, 10);
    wb(1'b1, 8'h00, 32'h00000008);
    wait_st(ltssm_pkg::ST_DETECT, 10); // warm reset
    wb(1'b1, 8'h00, 32'h0);
    pulse_term(1'b1);
    wait_st(ltssm_pkg::ST_LFPS, 10);
    wb(1'b1, 8'h00, 32'h00000004);
    wait_st(ltssm_pkg::ST_DISABLED, 10); // directed disable
    wb(1'b1, 8'h00, 32'h00000100);
    wait_st(ltssm_pkg::ST_DETECT, 10);
    // Peripheral role: detected warm reset, then timeout fallback
    wb(1'b1, 8'h00, 32'h00000002);
    pulse_term(1'b1);
    wait_st(ltssm_pkg::ST_LFPS, 10);
    @(posedge clk_i);
    b_ev.warm_det <= 1'b1;
    @(posedge clk_i);
    b_ev <= '0;
    wait_st(ltssm_pkg::ST_DETECT, 10); // upstream warm reset
    pulse_term(1'b1);
    wait_st(ltssm_pkg::ST_LFPS, 10);
    wait_st(ltssm_pkg::ST_DISABLED, 5100); // peripheral fallback
    tally_and_finish;
  end
endmodule // superspeed_link_training_polling_bench
